// File: common/hb_pkg.sv
package hb_pkg;

	// ------------------------------------------------------------
	// Word layout
	// ------------------------------------------------------------
	localparam int WORD_BITS = 16;
	localparam int CNT_W = 4;
	localparam int CH = 6;
	localparam int SW = 12;
	localparam int CMD_CLR = 0;
	localparam int ST_TW = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] STAT_RESET = 16'h0000;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 20;
	localparam int DEAD_NS = 1500;
	localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int DEAD_W = 7;
	localparam int OC_SHORT_US = 25;
	localparam int OC_LONG_US = 200;
	localparam int OC_SHORT_CYC = OC_SHORT_US * 1000 / CLK_NS;
	localparam int OC_LONG_CYC = OC_LONG_US * 1000 / CLK_NS;
	localparam int OC_W = 14;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic overvoltage_lockout_en;
		logic ulsd_en;
		logic oc_short;
		logic [SW-1:0] sw;
		logic status_clear;
	} hb_cmd_s;

	typedef struct packed {
		logic supply_fault;
		logic underload_flag;
		logic overload_flag;
		logic [SW-1:0] sw;
		logic thermal_warning;
	} hb_stat_s;

	typedef struct packed {
		logic overvoltage_lockout;
		logic undervoltage_lockout;
		logic [SW-1:0] overcurrent;
		logic [SW-1:0] underload;
		logic [CH-1:0] therm_warn;
		logic [CH-1:0] therm_shut;
	} hb_sense_s;

	typedef enum logic [1:0] {
		FR_IDLE = 2'b00,
		FR_ACTIVE = 2'b01,
		FR_COMMIT = 2'b11
	} hb_frame_e;

endpackage

// File: rtl/hb_gate.sv
`timescale 1ns/1ps
module hb_gate (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_hs,
	input wire logic req_ls,
	output logic hs,
	output logic ls
);
	logic [hb_pkg::DEAD_W-1:0] hs_off;
	logic [hb_pkg::DEAD_W-1:0] ls_off;
	localparam logic [hb_pkg::DEAD_W-1:0] DEAD =
		hb_pkg::DEAD_W'(hb_pkg::DEAD_CYC);

	wire hs_done = hs_off >= DEAD;
	wire ls_done = ls_off >= DEAD;

	always_ff @(posedge clk) begin
		if (rst) begin
			hs <= 1'b0;
			ls <= 1'b0;
			hs_off <= '0;
			ls_off <= '0;
		end else begin
			hs <= req_hs & ~req_ls & ~ls & ls_done;
			ls <= req_ls & ~req_hs & ~hs & hs_done;
			hs_off <= hs ? '0 : (hs_done ? hs_off : hs_off + 1'b1);
			ls_off <= ls ? '0 : (ls_done ? ls_off : ls_off + 1'b1);
		end
	end
endmodule

// File: rtl/hb_spi_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Command and status words are 16 bits, least significant bit first.
// - Transfer runs only while select_n is low; it idles high.
// - Serial input bits are captured on the falling serial clock edge.
// - Next status bit driven on each rising edge, bit 0 first.
// - Select rising copies a valid received word into the control register while enable is high.
// - Serial output is released whenever select_n is high.
// - Frame accepted only for a whole multiple of 16 edges.
// - Command bit 15 enables overvoltage lockout.
// - Command bit 14 enables shutdown on under-load.
// - Command bit 13 picks 25 us or 200 us overcurrent delay.
// - Bits 12..1 switch outputs; odd low side, even high side.
// - Command bit 0 requests a reset of the latched status.
// - Status bit 15 flags overvoltage or undervoltage supply fault.
// - Status bit 14 flags an under-load fault.
// - Status bit 13 flags an overload fault.
// - Status bits 12..1 show each switch state.
// - Status bit 0 flags a thermal warning from any sensor.
// - Six pair sensors; shutdown level turns that pair off.
// - A running overcurrent delay ignores later bit 13 changes.
// - At least 1.5 us between one switch off and opposite on.
// - Under-load is flagged per switched-on driver with low current.
module hb_spi_ctrl #(
	parameter int OC_LONG_CYC = hb_pkg::OC_LONG_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic select_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire hb_pkg::hb_sense_s sense,
	output logic [hb_pkg::CH-1:0] high_side_switch,
	output logic [hb_pkg::CH-1:0] low_side_switch
);

	// ------------------------------------------------------------
	// Constants
	// ------------------------------------------------------------
	localparam int SYNC_W = 2 + $bits(hb_pkg::hb_sense_s);
	localparam logic [SYNC_W-1:0] SYNC_RESET =
		{1'b1, {(SYNC_W - 1){1'b0}}};
	localparam logic [hb_pkg::OC_W-1:0] OC_SHORT_LIM =
		hb_pkg::OC_W'(hb_pkg::OC_SHORT_CYC - 1);
	localparam logic [hb_pkg::OC_W-1:0] OC_LONG_LIM =
		hb_pkg::OC_W'(OC_LONG_CYC - 1);

	// Last count of the overcurrent delay for a latched selection
	function automatic logic [hb_pkg::OC_W-1:0] oc_limit(
		input logic short_sel
	);
		oc_limit = short_sel ? OC_SHORT_LIM : OC_LONG_LIM;
	endfunction

	// Sticky flag where a new event beats a clear
	function automatic logic sticky(
		input logic cur,
		input logic evt,
		input logic clr
	);
		sticky = evt | (cur & ~clr);
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			sync_meta <= SYNC_RESET;
			sync_q <= SYNC_RESET;
		end else begin
			sync_meta <= {select_n, enable, sense};
			sync_q <= sync_meta;
		end
	end

	wire sel_s = sync_q[SYNC_W-1];
	wire en_s = sync_q[SYNC_W-2];
	hb_pkg::hb_sense_s sense_s;
	assign sense_s = sync_q[SYNC_W-3:0];

	// ------------------------------------------------------------
	// Serial link
	// ------------------------------------------------------------
	logic [15:0] stat_hold;
	logic [15:0] rx_word;
	logic rx_valid;

	hb_spi_link u_link (
		.sclk(sclk),
		.select_n(select_n),
		.enable(enable),
		.sdi(sdi),
		.stat(stat_hold),
		.sdo(sdo),
		.sdo_oe(sdo_oe),
		.rx_word(rx_word),
		.rx_valid(rx_valid)
	);

	// ------------------------------------------------------------
	// Frame tracking
	// ------------------------------------------------------------
	hb_pkg::hb_frame_e state;
	hb_pkg::hb_frame_e next_state;

	always_comb begin
		next_state = state;
		case (state)
			hb_pkg::FR_IDLE: begin
				if (!sel_s) begin
					next_state = hb_pkg::FR_ACTIVE;
				end
			end
			hb_pkg::FR_ACTIVE: begin
				if (sel_s) begin
					next_state = hb_pkg::FR_COMMIT;
				end
			end
			hb_pkg::FR_COMMIT: begin
				next_state = hb_pkg::FR_IDLE;
			end
			default: begin
				next_state = hb_pkg::FR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= hb_pkg::FR_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Link registers are still once select is high and synced
	wire commit = state == hb_pkg::FR_COMMIT;
	wire accept = commit & rx_valid & en_s;
	wire clr = accept & rx_word[hb_pkg::CMD_CLR];

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	hb_pkg::hb_cmd_s ctrl;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= hb_pkg::CTRL_RESET;
		end else if (accept) begin
			ctrl <= rx_word;
		end
	end

	// ------------------------------------------------------------
	// Fault detection
	// ------------------------------------------------------------
	logic [hb_pkg::SW-1:0] sw_on;
	logic [hb_pkg::SW-1:0] sw_off_lat;
	logic [hb_pkg::SW-1:0] oc_run;
	logic [hb_pkg::SW-1:0] oc_sel;
	logic [hb_pkg::SW-1:0] oc_expire;
	logic [hb_pkg::OC_W-1:0] oc_cnt [hb_pkg::SW];
	logic supply_fault;
	logic underload_flag;
	logic overload_flag;
	logic thermal_warning;

	// lockout only when enabled for overvoltage
	wire supply_evt = (sense_s.overvoltage_lockout & ctrl.overvoltage_lockout_en)
		| sense_s.undervoltage_lockout;
	wire [hb_pkg::SW-1:0] ul_evt = sense_s.underload & sw_on;
	// bit 14 turns flag into shutdown
	wire [hb_pkg::SW-1:0] ul_trip = ctrl.ulsd_en ? ul_evt : '0;
	wire [hb_pkg::SW-1:0] oc_evt = sense_s.overcurrent & sw_on;
	wire tw_evt = |sense_s.therm_warn;

	// Each timer counts cycles the overcurrent persists
	always_comb begin
		for (int i = 0; i < hb_pkg::SW; i++) begin
			oc_expire[i] = oc_run[i] & oc_evt[i]
				& (oc_cnt[i] == oc_limit(oc_sel[i]));
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			oc_run <= '0;
			oc_sel <= '0;
			for (int i = 0; i < hb_pkg::SW; i++) begin
				oc_cnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < hb_pkg::SW; i++) begin
				if (!oc_evt[i] || oc_expire[i]) begin
					oc_run[i] <= 1'b0;
					oc_cnt[i] <= '0;
				end else if (!oc_run[i]) begin
					oc_run[i] <= 1'b1;
					oc_sel[i] <= ctrl.oc_short;
					oc_cnt[i] <= '0;
				end else begin
					oc_cnt[i] <= oc_cnt[i] + 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Latched status
	// ------------------------------------------------------------
	// bit 0 clears latches
	always_ff @(posedge clk) begin
		if (rst) begin
			supply_fault <= 1'b0;
			underload_flag <= 1'b0;
			overload_flag <= 1'b0;
			thermal_warning <= 1'b0;
			sw_off_lat <= '0;
		end else begin
			supply_fault <= sticky(supply_fault, supply_evt, clr);
			underload_flag <= sticky(underload_flag, |ul_evt, clr);
			overload_flag <= sticky(overload_flag, |oc_expire, clr);
			thermal_warning <= sticky(thermal_warning, tw_evt, clr);
			sw_off_lat <= (oc_expire | ul_trip)
				| (sw_off_lat & {hb_pkg::SW{~clr}});
		end
	end

	// ------------------------------------------------------------
	// Switch requests
	// ------------------------------------------------------------
	logic [hb_pkg::SW-1:0] therm_off;

	always_comb begin
		for (int k = 0; k < hb_pkg::CH; k++) begin
			therm_off[2*k] = sense_s.therm_shut[k];
			therm_off[2*k+1] = sense_s.therm_shut[k];
		end
	end

	wire [hb_pkg::SW-1:0] req = ctrl.sw & ~sw_off_lat & ~therm_off
		& ~oc_expire & {hb_pkg::SW{en_s & ~supply_evt}};

	// ------------------------------------------------------------
	// Half-bridge drivers
	// ------------------------------------------------------------
	// even req bits low side, odd req bits high side
	for (genvar k = 0; k < hb_pkg::CH; k++) begin : g_bridge
		hb_gate u_gate (
			.clk(clk),
			.rst(rst),
			.req_hs(req[2*k+1]),
			.req_ls(req[2*k]),
			.hs(high_side_switch[k]),
			.ls(low_side_switch[k])
		);
		assign sw_on[2*k] = low_side_switch[k];
		assign sw_on[2*k+1] = high_side_switch[k];
	end

	// ------------------------------------------------------------
	// Status word
	// ------------------------------------------------------------
	hb_pkg::hb_stat_s status;

	always_comb begin
		status.supply_fault = supply_fault;
		status.underload_flag = underload_flag;
		status.overload_flag = overload_flag;
		status.sw = sw_on;
		status.thermal_warning = thermal_warning;
	end

	// Frozen during a frame so the link sees a still word
	always_ff @(posedge clk) begin
		if (rst) begin
			stat_hold <= hb_pkg::STAT_RESET;
		end else if (state == hb_pkg::FR_IDLE && sel_s) begin
			stat_hold <= status;
		end
	end

endmodule

// File: rtl/hb_spi_link.sv
`timescale 1ns/1ps
module hb_spi_link (
	input wire logic sclk,
	input wire logic select_n,
	input wire logic enable,
	input wire logic sdi,
	input wire logic [15:0] stat,
	output logic sdo,
	output logic sdo_oe,
	output logic [15:0] rx_word,
	output logic rx_valid
);
	logic mid;
	logic words;
	logic [hb_pkg::CNT_W-1:0] cnt;
	logic [15:0] shreg;

	// ------------------------------------------------------------
	// Receive side
	// ------------------------------------------------------------
	// Marks first falling edge; cleared while deselected
	always_ff @(negedge sclk or posedge select_n) begin
		if (select_n) begin
			mid <= 1'b0;
		end else begin
			mid <= 1'b1;
		end
	end

	always_ff @(negedge sclk) begin
		if (!select_n) begin
			if (!mid) begin
				cnt <= 4'h1;
				words <= 1'b0;
				shreg <= {sdi, stat[15:1]};
			end else begin
				cnt <= cnt + 4'h1;
				if (cnt == 4'hF) begin
					words <= 1'b1;
				end
				shreg <= {sdi, shreg[15:1]};
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit side
	// ------------------------------------------------------------
	// drive on rise
	always_ff @(posedge sclk or posedge select_n) begin
		if (select_n) begin
			sdo <= 1'b0;
		end else begin
			sdo <= mid ? shreg[0] : stat[0];
		end
	end

	assign sdo_oe = ~select_n & enable;
	assign rx_valid = words & (cnt == 4'h0);
	assign rx_word = shreg;
endmodule

// File: testbench/hb_host.sv
`timescale 1ns/1ps
module hb_host (
	output logic sclk,
	output logic select_n,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic [31:0] got;
	event done;

	initial begin
		sclk = 1'b0;
		select_n = 1'b1;
		sdi = 1'b0;
	end

	task automatic xfer(input logic [31:0] w, input int n);
		got = '0;
		#10 select_n = 1'b0;
		#128;
		for (int k = 0; k < n; k++) begin
			sdi = w[k];
			#31 sclk = 1'b1;
			#32 sclk = 1'b0;
			// Released pin reads as a toggling pattern
			got[k] = sdo_oe ? sdo : k[0];
			#1;
		end
		#64 sdi = 1'b0;
		select_n = 1'b1;
		#200 -> done;
	endtask
endmodule

// File: testbench/hb_spi_ctrl_monitor.sv
`timescale 1ns/1ps
module hb_spi_ctrl_monitor #(
	parameter int OC_LONG_CYC = 10000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic select_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire hb_pkg::hb_sense_s sense,
	input wire logic [hb_pkg::CH-1:0] high_side_switch,
	input wire logic [hb_pkg::CH-1:0] low_side_switch
);
	// ------------------------------------------------------------
	// Frame history and off timers
	// ------------------------------------------------------------
	logic [5:0] falls;
	logic [15:0] hist;
	logic [6:0] hs_off [6];
	logic [6:0] ls_off [6];

	// Cleared by select itself, as sclk stands still between frames
	always_ff @(negedge sclk or posedge select_n) begin
		if (select_n) begin
			falls <= 6'h00;
		end else begin
			falls <= falls + 6'(falls != 6'h3F);
			hist <= {hist[14:0], sdi};
		end
	end

	sequence dis_held;
		!enable [*6];
	endsequence

	sequence uv_held;
		sense.undervoltage_lockout [*6];
	endsequence

	oe_release_a: assert property (@(posedge clk) disable iff (rst)
		sdo_oe == (!select_n && enable)) else $error("sdo_oe wrong");

	chain_pass_a: assert property (@(negedge sclk)
		disable iff (select_n) falls >= 6'h10 |-> sdo == hist[15])
		else $error("sdo is not sdi delayed by 16");

	dis_off_a: assert property (@(posedge clk) disable iff (rst)
		dis_held |-> (high_side_switch | low_side_switch) == 6'h00)
		else $error("switch on while disabled");

	uv_off_a: assert property (@(posedge clk) disable iff (rst)
		uv_held |-> (high_side_switch | low_side_switch) == 6'h00)
		else $error("switch on during supply fault");

	for (genvar k = 0; k < 6; k++) begin : g_ch
		// Saturate so a long idle pair never wraps to a small count
		always_ff @(posedge clk) begin
			if (rst) begin
				hs_off[k] <= 7'h7F;
				ls_off[k] <= 7'h7F;
			end else begin
				hs_off[k] <= high_side_switch[k] ? 7'h00 :
					hs_off[k] + 7'(hs_off[k] != 7'h7F);
				ls_off[k] <= low_side_switch[k] ? 7'h00 :
					ls_off[k] + 7'(ls_off[k] != 7'h7F);
			end
		end

		pair_excl_a: assert property (@(posedge clk) disable iff (rst)
			!(high_side_switch[k] && low_side_switch[k]))
			else $error("both switches of a pair on");

		dead_ls_a: assert property (@(posedge clk) disable iff (rst)
			$rose(low_side_switch[k]) |-> hs_off[k] >= hb_pkg::DEAD_CYC)
			else $error("low side on too soon");

		dead_hs_a: assert property (@(posedge clk) disable iff (rst)
			$rose(high_side_switch[k]) |-> ls_off[k] >= hb_pkg::DEAD_CYC)
			else $error("high side on too soon");

		therm_off_a: assert property (@(posedge clk) disable iff (rst)
			sense.therm_shut[k] [*6] |->
			!high_side_switch[k] && !low_side_switch[k])
			else $error("pair on during thermal shutdown");
	end
endmodule

bind hb_spi_ctrl hb_spi_ctrl_monitor #(.OC_LONG_CYC(OC_LONG_CYC))
	hb_spi_ctrl_monitor_inst (
	.clk(clk), .rst(rst), .enable(enable), .select_n(select_n),
	.sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .sense(sense),
	.high_side_switch(high_side_switch), .low_side_switch(low_side_switch)
);

// File: testbench/test_hb_spi_ctrl.sv
`timescale 1ns/1ps
module test_hb_spi_ctrl;
	localparam int OCL = 200;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic enable = 1'b1;
	logic sclk, select_n, sdi, sdo, sdo_oe;
	logic [5:0] hs, ls;
	hb_pkg::hb_sense_s sense = '0;
	logic [15:0] exp_q[$];
	logic [15:0] fexp[4] = '{16'h8000, 16'h4002, 16'h0003, 16'h8000};
	int error_cnt = 0;
	int samples_checked = 0;

	always #10 clk = ~clk;

	hb_spi_ctrl #(.OC_LONG_CYC(OCL)) hb_spi_ctrl_inst (
		.clk(clk), .rst(rst), .enable(enable), .select_n(select_n),
		.sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
		.sense(sense), .high_side_switch(hs), .low_side_switch(ls)
	);
	hb_host hb_host_inst (
		.sclk(sclk), .select_n(select_n), .sdi(sdi), .sdo(sdo),
		.sdo_oe(sdo_oe)
	);

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input string what, input logic [15:0] e,
		input logic [15:0] s);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic check_sw(input logic [11:0] e);
		logic [11:0] v;
		for (int k = 0; k < 6; k++) begin
			v[2*k] = ls[k];
			v[2*k+1] = hs[k];
		end
		check("switches", {4'h0, e}, {4'h0, v});
	endtask

	task automatic frame(input logic [31:0] w, input int n,
		input logic [15:0] e);
		exp_q.push_back(e);
		hb_host_inst.xfer(w, n);
	endtask

	always @(hb_host_inst.done) begin
		check("status", exp_q.pop_front(), hb_host_inst.got[15:0]);
	end

	task automatic print_verdict();
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		#1000000;
		error_cnt++;
		print_verdict();
	end

	initial begin
		logic [31:0] r;
		logic [15:0] c;
		logic [11:0] v;
		logic [11:0] p;
		r = $urandom(32'h19F8BEFB);
		tick(2);
		rst = 1'b0;
		tick(4);
		check("sdo_oe", 16'h0000, {15'h0000, sdo_oe});
		v = '0;
		// Pair code 3 asks for both sides and must give neither
		for (int i = 0; i < 4; i++) begin
			r = $urandom();
			c = {r[31:29], 13'h0000};
			p = v;
			for (int k = 0; k < 6; k++) begin
				c[2*k+1] = r[2*k];
				c[2*k+2] = r[2*k+1];
				v[2*k] = r[2*k] & ~r[2*k+1];
				v[2*k+1] = r[2*k+1] & ~r[2*k];
			end
			frame({16'h0000, c}, 16, {3'b000, p, 1'b0});
			tick(100);
			check_sw(v);
		end
		for (int n = 15; n < 18; n += 2) begin
			frame({16'h0000, ~c}, n, {3'b000, v, 1'b0});
			tick(100);
			check_sw(v);
		end
		r = $urandom();
		frame({16'h0004, r[15:0]}, 32, {3'b000, v, 1'b0});
		check("chain", r[15:0], hb_host_inst.got[31:16]);
		tick(100);
		check_sw(12'h002);
		enable = 1'b0;
		frame(32'h0000_0008, 16, 16'hAAAA);
		tick(100);
		check_sw(12'h000);
		enable = 1'b1;
		tick(100);
		check_sw(12'h002);
		frame(32'h0000_0002, 16, 16'h0004);
		tick(100);
		sense.overcurrent[0] = 1'b1;
		// Short delay picked while the long one already runs
		frame(32'h0000_2002, 16, 16'h0002);
		tick(50);
		check_sw(12'h001);
		tick(100);
		check_sw(12'h000);
		sense.overcurrent[0] = 1'b0;
		frame(32'h0000_2003, 16, 16'h2000);
		tick(100);
		check_sw(12'h001);
		// Short delay now selected: must outlast the long one
		sense.overcurrent[0] = 1'b1;
		tick(1200);
		check_sw(12'h001);
		tick(100);
		check_sw(12'h000);
		sense.overcurrent[0] = 1'b0;
		frame(32'h0000_2003, 16, 16'h2000);
		tick(100);
		frame(32'h0000_8002, 16, 16'h0002);
		for (int i = 0; i < 4; i++) begin
			tick(100);
			case (i)
				0: sense.undervoltage_lockout = 1'b1;
				1: sense.underload[0] = 1'b1;
				2: sense.therm_warn[0] = 1'b1;
				default: sense.overvoltage_lockout = 1'b1;
			endcase
			tick(20);
			frame(32'h0000_8002, 16, fexp[i]);
			tick(1);
			sense = '0;
			tick(100);
			frame(32'h0000_8003, 16, fexp[i] | 16'h0002);
		end
		tick(100);
		frame(32'h0000_8002, 16, 16'h0002);
		tick(1);
		sense.therm_shut[0] = 1'b1;
		tick(20);
		check_sw(12'h000);
		print_verdict();
	end
endmodule
